// File: src/exec_unit_pkg.sv
package exec_unit_pkg;

  // Operations this unit executes
  typedef enum logic [4:0] {
    OP_NOP, OP_CLR_WATCHDOG, OP_BIT_INVERT, OP_BIT_INVERT_A, OP_DECIMAL_ADJUST,
    OP_DEC, OP_DEC_A, OP_INC, OP_INC_A, OP_SLEEP, OP_JUMP,
    OP_MOV_A_MEM, OP_MOV_A_IMM, OP_MOV_MEM_A,
    OP_OR_MEM, OP_OR_IMM, OP_OR_TO_MEM,
    OP_RET, OP_RET_LIT, OP_INTERRUPT_RETURN,
    OP_ROT_L, OP_ROT_L_A, OP_ROT_LC, OP_ROT_LC_A,
    OP_ROT_R, OP_ROT_R_A, OP_ROT_RC, OP_ROT_RC_A,
    OP_SUB_BORROW
  } op_t;

  // Status flags kept by the unit
  typedef struct packed {
    logic carry;
    logic half_byte_borrow_bit;
    logic null_bit;
    logic signed_excess_bit;
    logic signed_extra_bit;
    logic chained_null_bit;
    logic watchdog_expired_flag;
    logic sleep_entered_flag;
  } flags_t;

  // One decoded instruction from the decoder
  typedef struct packed {
    op_t         op;
    logic [7:0]  operand;
    logic [12:0] target;
  } instr_t;

  // Nibble limit and decimal corrections
  localparam logic [3:0] NIBBLE_MAX     = 4'h9;
  localparam logic [7:0] ADJ_LOW        = 8'h06;
  localparam logic [7:0] ADJ_HIGH       = 8'h60;
  localparam logic [7:0] ADJ_BOTH       = 8'h66;
  localparam logic [7:0] ADJ_NONE       = 8'h00;
  // Reset values and jump cycle count
  localparam logic [7:0] ACC_RESET      = 8'h00;
  localparam flags_t     FLAGS_RESET    = '0;
  localparam logic [1:0] JUMP_CYCLES    = 2'h2;

endpackage

// File: src/exec_unit.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Watchdog clear resets counter, expired, sleep flags
// - Invert byte, write memory or accumulator, null
// - Low nibble over nine or half-carry: add six
// - High nibble over nine or carry: add six
// - Decimal adjust writes memory, may change carry
// - Decrement by one, only null updated
// - Increment by one, only null updated
// - Power-down halts and stops clock, keeps state
// - Power-down clears watchdog, sets sleep flag
// - Jump loads target, two cycles, no flags
// - Moves copy bytes without touching flags
// - OR into accumulator or memory, null updated
// - Return pops program counter, no flags
// - Literal return pops and loads accumulator
// - Interrupt return pops and sets master enable
// - Pending interrupt serviced before main program
// - Rotate left wraps bit seven to zero
// - Rotate left through carry swaps carry, bit7
// - Rotate right wraps bit zero to seven
// - Rotate right through carry swaps carry, bit0
// - Accumulator rotate forms leave memory unchanged
// - Subtract with borrow updates six flags
// - Carry is not-borrow after subtraction
module exec_unit #(
  parameter int PC_WIDTH = 13
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Decoded instruction in
  input  wire logic                instr_valid,
  input  wire exec_unit_pkg::instr_t instr,
  output logic                     instr_ready,
  // Data memory operand and write-back
  input  wire logic [7:0]          mem_rdata,
  output logic                     mem_we,
  output logic [7:0]               mem_wdata,
  // Program counter and stack
  input  wire logic [PC_WIDTH-1:0] stack_top,
  output logic                     pc_load,
  output logic [PC_WIDTH-1:0]      pc_value,
  output logic                     stack_pop,
  // Interrupt and power
  input  wire logic                irq_pending,
  output logic                     irq_service,
  output logic                     master_irq_enable,
  output logic                     watchdog_clear,
  output logic                     clock_stop,
  // Architectural state
  output logic [7:0]               acc,
  output exec_unit_pkg::flags_t    flags
);

  // Execution phases; the jump dummy cycle lives in DUMMY
  typedef enum logic [1:0] {RUN, DUMMY, ASLEEP} phase_t;

  phase_t                 phase, next_phase;        // Current phase
  logic [7:0]             next_acc;                 // Accumulator next value
  exec_unit_pkg::flags_t  next_flags;               // Flags next value
  logic                   next_mie;                 // Master enable next value
  logic                   next_mem_we;              // Write strobe next value
  logic [7:0]             next_mem_wdata;           // Write data next value
  logic                   next_pc_load;             // PC load next value
  logic [PC_WIDTH-1:0]    next_pc_value;            // PC value next value
  logic                   next_stack_pop;           // Pop next value
  logic                   next_irq_service;         // Service request next value
  logic                   next_wd_clear;            // Watchdog clear next value
  logic [7:0]             result;                   // Byte computed this cycle
  logic [7:0]             adj;                      // Decimal correction
  logic [8:0]             dsum;                     // Adjusted sum with carry out
  logic [8:0]             diff;                     // Subtraction, bit 8 is borrow
  logic [4:0]             ldiff;                    // Low nibble subtraction
  logic                   borrow_in;                // Inverted carry

  // Handshake: instructions are taken only while running
  assign instr_ready = (phase == RUN);
  assign clock_stop  = (phase == ASLEEP);

  // Arithmetic helpers shared by several operations
  always_comb begin
    borrow_in = ~flags.carry;
    // Subtract operand and inverted carry, nine bits to expose borrow
    diff  = {1'b0, acc} - {1'b0, mem_rdata} - {8'h00, borrow_in};
    ldiff = {1'b0, acc[3:0]} - {1'b0, mem_rdata[3:0]} - {4'h0, borrow_in};
    // Choose one of the four decimal corrections
    adj = decimal_addend(acc, flags);
    dsum = {1'b0, acc} + {1'b0, adj};
  end

  // Pick the decimal addend from nibble values and flags
  function automatic logic [7:0] decimal_addend(input logic [7:0] a,
                                                input exec_unit_pkg::flags_t f);
    logic lo;
    logic hi;
    lo = (a[3:0] > exec_unit_pkg::NIBBLE_MAX) || f.half_byte_borrow_bit;
    hi = (a[7:4] > exec_unit_pkg::NIBBLE_MAX) || f.carry;
    case ({hi, lo})
      2'b01:   decimal_addend = exec_unit_pkg::ADJ_LOW;
      2'b10:   decimal_addend = exec_unit_pkg::ADJ_HIGH;
      2'b11:   decimal_addend = exec_unit_pkg::ADJ_BOTH;
      default: decimal_addend = exec_unit_pkg::ADJ_NONE;
    endcase
  endfunction

  // Next state of the execution unit
  always_comb begin
    next_phase       = phase;
    next_acc         = acc;
    next_flags       = flags;
    next_mie         = master_irq_enable;
    next_mem_we      = 1'b0;
    next_mem_wdata   = mem_wdata;
    next_pc_load     = 1'b0;
    next_pc_value    = pc_value;
    next_stack_pop   = 1'b0;
    next_irq_service = 1'b0;
    next_wd_clear    = 1'b0;
    result           = 8'h00;
    unique case (phase)
      // Second half of a jump or return: nothing executes, dummy cycle
      DUMMY: begin
        next_phase = RUN;
      end
      // Clock is stopped; only reset leaves this phase
      ASLEEP: begin
        next_phase = ASLEEP;
      end
      RUN: begin
        if (instr_valid) begin
          unique case (instr.op)
            exec_unit_pkg::OP_CLR_WATCHDOG: begin
              next_wd_clear = 1'b1;
              next_flags.watchdog_expired_flag = 1'b0;
              next_flags.sleep_entered_flag    = 1'b0;
            end
            exec_unit_pkg::OP_BIT_INVERT, exec_unit_pkg::OP_BIT_INVERT_A: begin
              result = ~mem_rdata;
              next_flags.null_bit = (result == 8'h00);
              if (instr.op == exec_unit_pkg::OP_BIT_INVERT_A) next_acc = result;
              else begin
                next_mem_we    = 1'b1;
                next_mem_wdata = result;
              end
            end
            exec_unit_pkg::OP_DECIMAL_ADJUST: begin
              next_mem_we    = 1'b1;
              next_mem_wdata = dsum[7:0];
              // Carry only ever rises: a decimal sum above 99 must stick
              if (dsum[8] || (adj[6] && (acc[7:4] > exec_unit_pkg::NIBBLE_MAX)))
                next_flags.carry = 1'b1;
            end
            exec_unit_pkg::OP_DEC, exec_unit_pkg::OP_DEC_A,
            exec_unit_pkg::OP_INC, exec_unit_pkg::OP_INC_A: begin
              if (instr.op == exec_unit_pkg::OP_DEC || instr.op == exec_unit_pkg::OP_DEC_A)
                result = mem_rdata - 8'h01;
              else
                result = mem_rdata + 8'h01;
              next_flags.null_bit = (result == 8'h00);
              if (instr.op == exec_unit_pkg::OP_DEC_A || instr.op == exec_unit_pkg::OP_INC_A)
                next_acc = result;
              else begin
                next_mem_we    = 1'b1;
                next_mem_wdata = result;
              end
            end
            exec_unit_pkg::OP_SLEEP: begin
              next_phase    = ASLEEP;
              next_wd_clear = 1'b1;
              next_flags.sleep_entered_flag    = 1'b1;
              next_flags.watchdog_expired_flag = 1'b0;
            end
            exec_unit_pkg::OP_JUMP: begin
              next_pc_load  = 1'b1;
              next_pc_value = instr.target[PC_WIDTH-1:0];
              next_phase    = DUMMY;
            end
            exec_unit_pkg::OP_MOV_A_MEM: next_acc = mem_rdata;
            exec_unit_pkg::OP_MOV_A_IMM: next_acc = instr.operand;
            exec_unit_pkg::OP_MOV_MEM_A: begin
              next_mem_we    = 1'b1;
              next_mem_wdata = acc;
            end
            exec_unit_pkg::OP_OR_MEM, exec_unit_pkg::OP_OR_IMM,
            exec_unit_pkg::OP_OR_TO_MEM: begin
              result = acc | ((instr.op == exec_unit_pkg::OP_OR_IMM) ? instr.operand
                                                                    : mem_rdata);
              next_flags.null_bit = (result == 8'h00);
              if (instr.op == exec_unit_pkg::OP_OR_TO_MEM) begin
                next_mem_we    = 1'b1;
                next_mem_wdata = result;
              end else next_acc = result;
            end
            exec_unit_pkg::OP_RET, exec_unit_pkg::OP_RET_LIT,
            exec_unit_pkg::OP_INTERRUPT_RETURN: begin
              next_stack_pop = 1'b1;
              next_pc_load   = 1'b1;
              next_pc_value  = stack_top;
              next_phase     = DUMMY;
              if (instr.op == exec_unit_pkg::OP_RET_LIT)
                next_acc = instr.operand;
              if (instr.op == exec_unit_pkg::OP_INTERRUPT_RETURN) begin
                next_mie = 1'b1;
                // A waiting interrupt is taken before the popped address runs
                next_irq_service = irq_pending;
              end
            end
            exec_unit_pkg::OP_ROT_L, exec_unit_pkg::OP_ROT_L_A: begin
              result = {mem_rdata[6:0], mem_rdata[7]};
              if (instr.op == exec_unit_pkg::OP_ROT_L_A) next_acc = result;
              else begin
                next_mem_we    = 1'b1;
                next_mem_wdata = result;
              end
            end
            exec_unit_pkg::OP_ROT_LC, exec_unit_pkg::OP_ROT_LC_A: begin
              result = {mem_rdata[6:0], flags.carry};
              next_flags.carry = mem_rdata[7];
              if (instr.op == exec_unit_pkg::OP_ROT_LC_A) next_acc = result;
              else begin
                next_mem_we    = 1'b1;
                next_mem_wdata = result;
              end
            end
            exec_unit_pkg::OP_ROT_R, exec_unit_pkg::OP_ROT_R_A: begin
              result = {mem_rdata[0], mem_rdata[7:1]};
              if (instr.op == exec_unit_pkg::OP_ROT_R_A) next_acc = result;
              else begin
                next_mem_we    = 1'b1;
                next_mem_wdata = result;
              end
            end
            exec_unit_pkg::OP_ROT_RC, exec_unit_pkg::OP_ROT_RC_A: begin
              result = {flags.carry, mem_rdata[7:1]};
              next_flags.carry = mem_rdata[0];
              if (instr.op == exec_unit_pkg::OP_ROT_RC_A) next_acc = result;
              else begin
                next_mem_we    = 1'b1;
                next_mem_wdata = result;
              end
            end
            exec_unit_pkg::OP_SUB_BORROW: begin
              result   = diff[7:0];
              next_acc = result;
              next_flags.carry                = ~diff[8];
              next_flags.half_byte_borrow_bit = ~ldiff[4];
              // Overflow: operand signs differ and the result lost the minuend's sign
              next_flags.signed_excess_bit    = (acc[7] ^ mem_rdata[7]) & (acc[7] ^ result[7]);
              next_flags.null_bit             = (result == 8'h00);
              next_flags.signed_extra_bit     = result[7] ^ next_flags.signed_excess_bit;
              // Chained null is set only when this result is zero and the null flag was already set
              next_flags.chained_null_bit     = (result == 8'h00) && flags.null_bit;
            end
            default: ;
          endcase
        end
      end
      default: next_phase = RUN;
    endcase
  end

  // Register stage: all state, asynchronous reset to constants
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase             <= RUN;
      acc               <= exec_unit_pkg::ACC_RESET;
      flags             <= exec_unit_pkg::FLAGS_RESET;
      master_irq_enable <= 1'b0;
      mem_we            <= 1'b0;
      mem_wdata         <= 8'h00;
      pc_load           <= 1'b0;
      pc_value          <= '0;
      stack_pop         <= 1'b0;
      irq_service       <= 1'b0;
      watchdog_clear    <= 1'b0;
    end else begin
      phase             <= next_phase;
      acc               <= next_acc;
      flags             <= next_flags;
      master_irq_enable <= next_mie;
      mem_we            <= next_mem_we;
      mem_wdata         <= next_mem_wdata;
      pc_load           <= next_pc_load;
      pc_value          <= next_pc_value;
      stack_pop         <= next_stack_pop;
      irq_service       <= next_irq_service;
      watchdog_clear    <= next_wd_clear;
    end
  end

endmodule

`default_nettype wire

// File: tb/data_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// One data memory cell; the ops under test address a single byte
module data_mem_model (
  // Clock
  input  wire logic       clk_sys,
  // Bench preload
  input  wire logic       preload,
  input  wire logic [7:0] preload_value,
  // Unit side
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_wdata,
  output logic [7:0]      mem_rdata
);
  // Unit write-back wins, so a late preload never hides a result
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem_rdata <= mem_wdata;
    end else if (preload) begin
      mem_rdata <= preload_value;
    end
  end
endmodule
`default_nettype wire

// File: tb/exec_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
module exec_unit_sva #(
  parameter int PC_WIDTH = 13
) (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst,
  // Handshake
  input wire logic                  instr_valid,
  input wire exec_unit_pkg::instr_t instr,
  input wire logic                  instr_ready,
  // Memory and flow
  input wire logic [7:0]            mem_rdata,
  input wire logic                  mem_we,
  input wire logic [7:0]            mem_wdata,
  input wire logic [PC_WIDTH-1:0]   stack_top,
  input wire logic                  pc_load,
  input wire logic [PC_WIDTH-1:0]   pc_value,
  input wire logic                  stack_pop,
  // Interrupt and power
  input wire logic                  irq_pending,
  input wire logic                  irq_service,
  input wire logic                  master_irq_enable,
  input wire logic                  watchdog_clear,
  input wire logic                  clock_stop,
  // State
  input wire logic [7:0]            acc,
  input wire exec_unit_pkg::flags_t flags
);
  // Op taken at this edge; idle cycles read as no-op
  exec_unit_pkg::op_t took;
  assign took = (instr_valid && instr_ready) ? instr.op : exec_unit_pkg::OP_NOP;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_wd_clear: assert property (took == exec_unit_pkg::OP_CLR_WATCHDOG |=> watchdog_clear
    && !flags.watchdog_expired_flag && !flags.sleep_entered_flag) else $error("wd clear bad");
  a_invert_mem: assert property (took == exec_unit_pkg::OP_BIT_INVERT |=> mem_we
    && mem_wdata == ~$past(mem_rdata) && flags.null_bit == (mem_wdata == 8'h00)) else $error("inv bad");
  a_inc_wraps: assert property (took == exec_unit_pkg::OP_INC |=> mem_we
    && mem_wdata == $past(mem_rdata) + 8'h01) else $error("increment bad");
  a_jump_load: assert property (took == exec_unit_pkg::OP_JUMP |=> pc_load
    && pc_value == $past(instr.target) && !instr_ready ##1 instr_ready) else $error("jump bad");
  a_return_pop: assert property (took inside {exec_unit_pkg::OP_RET,
    exec_unit_pkg::OP_RET_LIT} |=> stack_pop && pc_value == $past(stack_top)) else $error("ret bad");
  a_irq_return: assert property (took == exec_unit_pkg::OP_INTERRUPT_RETURN |=>
    master_irq_enable && stack_pop && irq_service == $past(irq_pending)) else $error("iret bad");
  a_rotl_acc: assert property (took == exec_unit_pkg::OP_ROT_L_A |=> !mem_we
    && acc == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(flags)) else $error("rl bad");
  a_sleep_entry: assert property (took == exec_unit_pkg::OP_SLEEP |=> clock_stop
    && watchdog_clear && flags.sleep_entered_flag && !flags.watchdog_expired_flag) else $error("slp");
  a_stay_asleep: assert property (clock_stop |=> clock_stop && !instr_ready
    && $stable(acc)) else $error("woke without reset");
  a_sub_carry: assert property (took == exec_unit_pkg::OP_SUB_BORROW |=> flags.carry ==
    ({1'b0, $past(acc)} >= {1'b0, $past(mem_rdata)} + {8'h00, !$past(flags.carry)})) else $error("c");
endmodule
bind exec_unit exec_unit_sva #(.PC_WIDTH(PC_WIDTH)) exec_unit_sva_i (
  .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
  .instr_ready(instr_ready), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata),
  .stack_top(stack_top), .pc_load(pc_load), .pc_value(pc_value), .stack_pop(stack_pop),
  .irq_pending(irq_pending), .irq_service(irq_service), .master_irq_enable(master_irq_enable),
  .watchdog_clear(watchdog_clear), .clock_stop(clock_stop), .acc(acc), .flags(flags));
`default_nettype wire

// File: tb/exec_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module exec_unit_tb;
  // Jump target and stacked return address
  localparam logic [12:0] TGT = 13'h1ABC;
  localparam logic [12:0] RET_ADDR = 13'h0123;
  // Unit inputs, all defined at time zero
  logic                  clk_sys;
  logic                  rst = 1'b1;
  logic                  instr_valid = 1'b0;
  exec_unit_pkg::instr_t instr = '0;
  logic                  irq_pending = 1'b0;
  logic [12:0]           stack_top = RET_ADDR;
  logic                  preload = 1'b0;
  logic [7:0]            preload_value = 8'h00;
  // Unit outputs
  logic       instr_ready, mem_we, pc_load, stack_pop, irq_service;
  logic       master_irq_enable, watchdog_clear, clock_stop;
  logic [7:0] mem_rdata, mem_wdata, acc;
  logic [12:0] pc_value;
  exec_unit_pkg::flags_t flags, f;
  // Tallies
  int mismatches = 0;
  int checks = 0;
  exec_unit exec_unit_i (
    .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .stack_top(stack_top), .pc_load(pc_load), .pc_value(pc_value), .stack_pop(stack_pop),
    .irq_pending(irq_pending), .irq_service(irq_service), .master_irq_enable(master_irq_enable),
    .watchdog_clear(watchdog_clear), .clock_stop(clock_stop), .acc(acc), .flags(flags));
  data_mem_model data_mem_model_i (.clk_sys(clk_sys), .preload(preload),
    .preload_value(preload_value), .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Whole run is under two hundred cycles; this bound only cuts a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish();
  end
  task automatic chk_byte(input logic [7:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask
  // Hold the request until taken, then look one cycle later when pulses stand
  task automatic issue(input exec_unit_pkg::op_t op, input logic [7:0] opnd);
    int n;
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr <= '{op, opnd, TGT};
    #1;
    for (n = 0; n < 16 && instr_ready !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk_bit(instr_ready, 1'b1, "ready before take");
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask
  // Preload the cell, run one op, judge result, strobe and carry
  task automatic run(input exec_unit_pkg::op_t op, input logic [7:0] opnd, m, exp,
                     input logic to_mem, cy);
    @(posedge clk_sys);
    preload <= 1'b1;
    preload_value <= m;
    @(posedge clk_sys);
    preload <= 1'b0;
    issue(op, opnd);
    chk_bit(mem_we, to_mem, "write strobe");
    chk_byte(to_mem ? mem_wdata : acc, exp, "result");
    chk_bit(flags.carry, cy, "carry");
  endtask
  task automatic t_count();
    run(exec_unit_pkg::OP_INC, 8'h00, 8'hFF, 8'h00, 1'b1, 1'b0);
    chk_bit(flags.null_bit, 1'b1, "null");
    run(exec_unit_pkg::OP_INC_A, 8'h00, 8'h7F, 8'h80, 1'b0, 1'b0);
    run(exec_unit_pkg::OP_DEC, 8'h00, 8'h00, 8'hFF, 1'b1, 1'b0);
    run(exec_unit_pkg::OP_DEC_A, 8'h00, 8'h01, 8'h00, 1'b0, 1'b0);
    chk_bit(flags.null_bit, 1'b1, "null");
    run(exec_unit_pkg::OP_BIT_INVERT, 8'h00, 8'hA5, 8'h5A, 1'b1, 1'b0);
    run(exec_unit_pkg::OP_BIT_INVERT_A, 8'h00, 8'hFF, 8'h00, 1'b0, 1'b0);
  endtask
  task automatic t_move_or();
    f = flags;
    run(exec_unit_pkg::OP_MOV_A_IMM, 8'h50, 8'h00, 8'h50, 1'b0, 1'b0);
    run(exec_unit_pkg::OP_MOV_A_MEM, 8'h00, 8'h50, 8'h50, 1'b0, 1'b0);
    run(exec_unit_pkg::OP_MOV_MEM_A, 8'h00, 8'hEE, 8'h50, 1'b1, 1'b0);
    chk_byte(flags, f, "flags after moves");
    run(exec_unit_pkg::OP_OR_IMM, 8'h05, 8'h00, 8'h55, 1'b0, 1'b0);
    chk_bit(flags.null_bit, 1'b0, "null");
    run(exec_unit_pkg::OP_OR_TO_MEM, 8'h00, 8'h0A, 8'h5F, 1'b1, 1'b0);
    issue(exec_unit_pkg::OP_MOV_A_IMM, 8'h00);
    run(exec_unit_pkg::OP_OR_MEM, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    chk_bit(flags.null_bit, 1'b1, "null");
  endtask
  task automatic t_rotate();
    run(exec_unit_pkg::OP_ROT_L, 8'h00, 8'h81, 8'h03, 1'b1, 1'b0);
    run(exec_unit_pkg::OP_ROT_L_A, 8'h00, 8'h81, 8'h03, 1'b0, 1'b0);
    run(exec_unit_pkg::OP_ROT_R, 8'h00, 8'h81, 8'hC0, 1'b1, 1'b0);
    run(exec_unit_pkg::OP_ROT_R_A, 8'h00, 8'h81, 8'hC0, 1'b0, 1'b0);
    run(exec_unit_pkg::OP_ROT_LC, 8'h00, 8'h80, 8'h00, 1'b1, 1'b1);
    run(exec_unit_pkg::OP_ROT_LC_A, 8'h00, 8'h01, 8'h03, 1'b0, 1'b0);
    run(exec_unit_pkg::OP_ROT_RC, 8'h00, 8'h01, 8'h00, 1'b1, 1'b1);
    run(exec_unit_pkg::OP_ROT_RC_A, 8'h00, 8'h00, 8'h80, 1'b0, 1'b0);
  endtask
  // Accumulator value and expected byte for each decimal correction
  task automatic t_decimal();
    logic [7:0] a[5] = '{8'h45, 8'h0B, 8'hA2, 8'h12, 8'h9A};
    logic [7:0] r[5] = '{8'h45, 8'h11, 8'h02, 8'h72, 8'h00};
    logic       k[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 5; i++) begin
      issue(exec_unit_pkg::OP_MOV_A_IMM, a[i]);
      run(exec_unit_pkg::OP_DECIMAL_ADJUST, 8'h00, 8'h33, r[i], 1'b1, k[i]);
      chk_byte(acc, a[i], "acc kept");
    end
  endtask
  task automatic t_subtract();
    issue(exec_unit_pkg::OP_MOV_A_IMM, 8'h10);
    run(exec_unit_pkg::OP_SUB_BORROW, 8'h00, 8'h20, 8'hF0, 1'b0, 1'b0);
    issue(exec_unit_pkg::OP_MOV_A_IMM, 8'h10);
    run(exec_unit_pkg::OP_SUB_BORROW, 8'h00, 8'h0F, 8'h00, 1'b0, 1'b1);
    chk_bit(flags.null_bit, 1'b1, "null");
    issue(exec_unit_pkg::OP_MOV_A_IMM, 8'h80);
    run(exec_unit_pkg::OP_SUB_BORROW, 8'h00, 8'h01, 8'h7F, 1'b0, 1'b1);
    chk_bit(flags.signed_excess_bit, 1'b1, "overflow");
    chk_bit(flags.signed_extra_bit, 1'b1, "signed extra");
  endtask
  task automatic t_flow();
    f = flags;
    issue(exec_unit_pkg::OP_JUMP, 8'h00);
    chk_bit(pc_load && pc_value === TGT, 1'b1, "jump");
    chk_bit(instr_ready, 1'b0, "dummy cycle");
    chk_byte(flags, f, "flags after jump");
    issue(exec_unit_pkg::OP_RET_LIT, 8'h77);
    chk_bit(stack_pop && pc_value === RET_ADDR, 1'b1, "pop");
    chk_byte(acc, 8'h77, "literal");
    irq_pending <= 1'b1;
    issue(exec_unit_pkg::OP_INTERRUPT_RETURN, 8'h00);
    chk_bit(master_irq_enable, 1'b1, "enable");
    chk_bit(irq_service, 1'b1, "service");
    irq_pending <= 1'b0;
  endtask
  task automatic t_power();
    issue(exec_unit_pkg::OP_CLR_WATCHDOG, 8'h00);
    chk_bit(watchdog_clear, 1'b1, "wd clear");
    chk_byte({6'h00, flags[1:0]}, 8'h00, "wd flags");
    issue(exec_unit_pkg::OP_SLEEP, 8'h00);
    chk_bit(watchdog_clear && flags.sleep_entered_flag, 1'b1, "sleep");
    chk_bit(flags.watchdog_expired_flag, 1'b0, "expired");
    repeat (3) @(posedge clk_sys);
    chk_bit(clock_stop && !instr_ready, 1'b1, "halted");
    chk_byte(acc, 8'h77, "acc kept");
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_count();
    t_move_or();
    t_rotate();
    t_decimal();
    t_subtract();
    t_flow();
    t_power();
    tally_and_finish();
  end
endmodule
`default_nettype wire
